// [udr_pkg.sv]
// constants and carrier types for the dual-role line control and interrupt register bank
package udr_pkg;

  // register addresses on the serial register port
  localparam logic [7:0] UDR_CTRL_SET_ADDR = 8'h06;
  localparam logic [7:0] UDR_CTRL_CLR_ADDR = 8'h07;
  localparam logic [7:0] UDR_SRC_ADDR = 8'h08;
  localparam logic [7:0] UDR_LATCH_SET_ADDR = 8'h0A;
  localparam logic [7:0] UDR_LATCH_CLR_ADDR = 8'h0B;
  localparam logic [7:0] UDR_STAT_ADDR = 8'h10;

  // values after reset
  localparam logic [7:0] UDR_CTRL_RST = 8'h0C;
  localparam logic [7:0] UDR_LATCH_RST = 8'h00;
  localparam logic [7:0] UDR_SRC_RST = 8'h00;
  localparam logic [7:0] UDR_STAT_RST = 8'h00;
  localparam logic [7:0] UDR_RD_RST = 8'h00;
  localparam logic [5:0] UDR_STAT_RSVD = 6'h00;

  // field positions
  localparam int UDR_CTRL_DPLUS_UP_BIT = 0;
  localparam int UDR_SRC_ACON_BIT = 6;
  localparam int UDR_STAT_VALID_BIT = 7;
  localparam int UDR_STAT_ENDED_BIT = 6;

  // synchroniser width: sensed pins plus the transmit enable
  localparam int UDR_SYNC_W = 10;

  // register write request from the serial protocol engine
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } udr_wr_t;

  // analog comparator and line sense levels; bits 5..0 in source register order, bit 6 the carkit level, bits 8..7 the status levels
  typedef struct packed {
    logic bdev_session_valid;
    logic bdev_session_ended;
    logic carkit_irq_level;
    logic id_open;
    logic dminus_high;
    logic id_grounded;
    logic dplus_high;
    logic session_valid_cmp;
    logic adev_supply_valid_cmp;
  } udr_sense_t;

  // line and supply switch enables, bit 7 down to bit 0
  typedef struct packed {
    logic supply_charge_en;
    logic supply_discharge_en;
    logic supply_pump_drive_en;
    logic id_ground_en;
    logic dminus_low_res_en;
    logic dplus_low_res_en;
    logic dminus_high_res_en;
    logic dplus_high_res_en;
  } udr_line_ctrl_t;

endpackage

// [udr_sync.sv]
// two-stage synchroniser for pin levels entering the clock domain
module udr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } udr_sync_state_t;

  udr_sync_state_t st_q;
  udr_sync_state_t st_d;

  // the first stage feeds only the second stage
  always_comb
  begin
    st_d = st_q;
    st_d.meta = async_i;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.stable;

endmodule

// [udr_regs.sv]
// line control, session status, interrupt source and interrupt latch register bank
// Summary of operation
// - control register set at 06h, cleared at 07h, bit by bit
// - control resets to 0Ch: only both data-line pull-downs on
// - control bit 7 charges the supply line through a resistor
// - control bit 6 discharges the supply line to ground
// - control bit 5 enables the charge pump driving the supply line
// - control bit 4 ties the ID pin to ground
// - bits 3 and 2 switch D- and D+ pull-downs
// - bits 1 and 0 switch D- and D+ pull-ups
// - session status read-only at 10h, resets zero, bits 5..0 reserved
// - status bit 7 follows the session-valid comparator
// - status bit 6 follows the session-end comparator
// - source register at 08h reads live unlatched levels, resets zero
// - source bit 7 is the carkit comparator on D+
// - source bit 6 shows auto-connect has raised the D+ pull-up
// - source bits 5,4,3,2: ID open, D- high, ID grounded, D+ high
// - source bit 1 is the session-valid comparator
// - source bit 0 is the A-device supply-valid comparator
// - latch register set at 0Ah, cleared at 0Bh
// - each latch bit records change of same-position source, resets zero
// - ones written set or clear; zeros written do nothing
// - latch sets on enabled rising or falling source edge
// - auto-connect watches for SE0 while idle and raises D+ pull-up
module udr_regs
  import udr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register port from the serial protocol engine
  input wire udr_pkg::udr_wr_t wr_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // pins and comparators, asynchronous
  input wire udr_pkg::udr_sense_t sense_i,
  input wire logic tx_oe_active_i,
  // controls from the mode and enable registers
  input wire logic auto_connect_enable_i,
  input wire logic [7:0] rise_irq_en_i,
  input wire logic [7:0] fall_irq_en_i,
  // line switches and interrupt state
  output udr_pkg::udr_line_ctrl_t line_ctrl_o,
  output logic [7:0] src_o,
  output logic [7:0] latch_o
);

  import udr_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] latch;
    logic [7:0] src_prev;
    logic acon_done;
    logic [7:0] rd_data;
  } udr_state_t;

  udr_state_t st_q;
  udr_state_t st_d;
  logic [UDR_SYNC_W-1:0] sync_s;
  udr_sense_t sense_s;
  logic tx_active_s;
  logic [7:0] src;
  logic [7:0] stat;
  logic [7:0] edge_set;
  logic acon_fire;

  // mask of ones written to one address, zero when not addressed
  function automatic logic [7:0] wr_mask(udr_wr_t w, logic [7:0] a);
    return (w.valid && (w.addr == a)) ? w.data : 8'h00;
  endfunction

  // pin levels are asynchronous to clk_i
  udr_sync #(
    .W(UDR_SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({tx_oe_active_i, sense_i}),
    .sync_o(sync_s)
  );

  assign sense_s = udr_sense_t'(sync_s[UDR_SYNC_W-2:0]);
  assign tx_active_s = sync_s[UDR_SYNC_W-1];

  // live source levels; zero after reset since synchroniser resets low
  assign src = {sense_s.carkit_irq_level,
                st_q.acon_done,
                sense_s.id_open,
                sense_s.dminus_high,
                sense_s.id_grounded,
                sense_s.dplus_high,
                sense_s.session_valid_cmp,
                sense_s.adev_supply_valid_cmp};

  // session status with reserved bits forced low
  assign stat = {sense_s.bdev_session_valid,
                 sense_s.bdev_session_ended,
                 UDR_STAT_RSVD};

  // enabled edges of each source; a level already high at reset counts as a rise
  always_comb
  begin
    edge_set = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      edge_set[i] = (rise_irq_en_i[i] && src[i] && !st_q.src_prev[i])
        || (fall_irq_en_i[i] && !src[i] && st_q.src_prev[i]);
    end
  end

  // single-ended zero seen while our transmitter is idle and pull-up is off
  assign acon_fire = auto_connect_enable_i && !tx_active_s
    && !sense_s.dplus_high && !sense_s.dminus_high
    && !st_q.ctrl[UDR_CTRL_DPLUS_UP_BIT];

  // next state: set beats clear everywhere so no event is lost
  always_comb
  begin
    st_d = st_q;
    st_d.ctrl = (st_q.ctrl & ~wr_mask(wr_i, UDR_CTRL_CLR_ADDR))
      | wr_mask(wr_i, UDR_CTRL_SET_ADDR);
    if (acon_fire)
    begin
      st_d.ctrl[UDR_CTRL_DPLUS_UP_BIT] = 1'b1;
    end
    st_d.latch = (st_q.latch & ~wr_mask(wr_i, UDR_LATCH_CLR_ADDR))
      | wr_mask(wr_i, UDR_LATCH_SET_ADDR) | edge_set;
    st_d.src_prev = src;
    // done flag drops once software withdraws the enable
    if (!auto_connect_enable_i)
    begin
      st_d.acon_done = 1'b0;
    end
    else if (acon_fire)
    begin
      st_d.acon_done = 1'b1;
    end
    if (rd_en_i)
    begin
      case (rd_addr_i)
        UDR_CTRL_SET_ADDR, UDR_CTRL_CLR_ADDR: st_d.rd_data = st_q.ctrl;
        UDR_SRC_ADDR: st_d.rd_data = src;
        UDR_LATCH_SET_ADDR, UDR_LATCH_CLR_ADDR: st_d.rd_data = st_q.latch;
        UDR_STAT_ADDR: st_d.rd_data = stat;
        default: st_d.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_q.ctrl <= UDR_CTRL_RST;
      st_q.latch <= UDR_LATCH_RST;
      st_q.src_prev <= UDR_SRC_RST;
      st_q.acon_done <= 1'b0;
      st_q.rd_data <= UDR_RD_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // switch enables drive the analog line and supply switches directly
  assign line_ctrl_o = udr_line_ctrl_t'(st_q.ctrl);
  assign src_o = src;
  assign latch_o = st_q.latch;
  assign rd_data_o = st_q.rd_data;

  // checks
  ctrl_reset_val_a: assert property (@(posedge clk_i)
    $rose(reset_n_i) |-> st_q.ctrl == UDR_CTRL_RST)
    else $error("control register not 0Ch after reset");

  ctrl_set_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_i.valid && wr_i.addr == UDR_CTRL_SET_ADDR)
    |=> (st_q.ctrl & $past(wr_i.data)) == $past(wr_i.data))
    else $error("control set address did not set bits");

  ctrl_clear_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_i.valid && wr_i.addr == UDR_CTRL_CLR_ADDR)
    |=> (st_q.ctrl & $past(wr_i.data) & 8'hFE) == 8'h00)
    else $error("control clear address did not clear bits");

  // an auto-connect in the same cycle legally raises bit 0 on its own
  ctrl_zero_keep_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_i.valid && wr_i.addr == UDR_CTRL_SET_ADDR && !acon_fire)
    |=> (st_q.ctrl & ~$past(wr_i.data)) == ($past(st_q.ctrl) & ~$past(wr_i.data)))
    else $error("zeros written to set address changed control bits");

  stat_read_val_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (rd_en_i && rd_addr_i == UDR_STAT_ADDR) |=> rd_data_o[5:0] == 6'h00
    && rd_data_o[UDR_STAT_VALID_BIT] == $past(sense_s.bdev_session_valid)
    && rd_data_o[UDR_STAT_ENDED_BIT] == $past(sense_s.bdev_session_ended))
    else $error("status read returned wrong value");

  src_read_live_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (rd_en_i && rd_addr_i == UDR_SRC_ADDR) |=> rd_data_o == $past(src))
    else $error("source read did not return live levels");

  latch_edge_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (edge_set != 8'h00) |=> (st_q.latch & $past(edge_set)) == $past(edge_set))
    else $error("enabled source edge not latched");

  latch_clear_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_i.valid && wr_i.addr == UDR_LATCH_CLR_ADDR && edge_set == 8'h00)
    |=> (st_q.latch & $past(wr_i.data)) == 8'h00)
    else $error("latch clear address did not clear bits");

  auto_connect_up_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    acon_fire |=> line_ctrl_o.dplus_high_res_en && src_o[UDR_SRC_ACON_BIT])
    else $error("auto-connect did not raise pull-up and flag");

  // control bits only move on a write or an auto-connect
  ctrl_hold_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !(wr_i.valid && (wr_i.addr == UDR_CTRL_SET_ADDR || wr_i.addr == UDR_CTRL_CLR_ADDR))
    && !acon_fire |=> st_q.ctrl == $past(st_q.ctrl))
    else $error("control register changed with no write");

  latch_set_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_i.valid && wr_i.addr == UDR_LATCH_SET_ADDR)
    |=> (st_q.latch & $past(wr_i.data)) == $past(wr_i.data))
    else $error("latch set address did not set bits");

  // with every edge enable off, source activity must never reach the latch
  latch_hold_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !(wr_i.valid && (wr_i.addr == UDR_LATCH_SET_ADDR || wr_i.addr == UDR_LATCH_CLR_ADDR))
    && rise_irq_en_i == 8'h00 && fall_irq_en_i == 8'h00
    |=> st_q.latch == $past(st_q.latch))
    else $error("latch changed with no write or enabled edge");

  // a reset in mid-run must leave no stale latch, source or read data
  reset_clean_a: assert property (@(posedge clk_i)
    $rose(reset_n_i) |-> st_q.latch == UDR_LATCH_RST && src_o == UDR_SRC_RST
    && rd_data_o == UDR_RD_RST)
    else $error("latch, source or read data not clear after reset");

  // main scenarios
  auto_connect_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    acon_fire);
  latch_edge_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    edge_set != 8'h00 ##[1:8] wr_i.valid && wr_i.addr == UDR_LATCH_CLR_ADDR);
  latch_fall_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    fall_irq_en_i != 8'h00 && edge_set != 8'h00);
  ctrl_set_clear_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_i.valid && wr_i.addr == UDR_CTRL_SET_ADDR)
    ##[1:20] (wr_i.valid && wr_i.addr == UDR_CTRL_CLR_ADDR));

endmodule

// [udr_host_model.sv]
// host controller model issuing byte writes and reads on the register port
module udr_host_model
  import udr_pkg::*;
(
  // clock
  input wire logic clk_i,
  // register port toward the bank
  output udr_pkg::udr_wr_t wr_o,
  output logic rd_en_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle port from time zero so the first edge sees no request
  initial
  begin
    wr_o = '0;
    rd_en_o = 1'b0;
    rd_addr_o = 8'h00;
  end

  // one byte, strobe held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = '{valid: 1'b1, addr: a, data: d};
    @(negedge clk_i);
    wr_o.valid = 1'b0;
  endtask

  // data is registered, so it is taken one edge after the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    rd_en_o = 1'b1;
    rd_addr_o = a;
    @(negedge clk_i);
    d = rd_data_i;
    rd_en_o = 1'b0;
  endtask
endmodule

// [usb_dual_role_ctrl_irq_regs_tb_top.sv]
// self-checking bench for the line control and interrupt register bank
module usb_dual_role_ctrl_irq_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import udr_pkg::*;

  `define CHK(n, e, g) \
    begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end

  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  udr_wr_t wr;
  logic rd_en;
  logic [7:0] rd_addr, rd_data, src, latch;
  logic [7:0] rise_en = 8'h00;
  logic [7:0] fall_en = 8'h00;
  udr_sense_t sense = '0;
  logic tx_oe = 1'b0;
  logic acon_en = 1'b0;
  udr_line_ctrl_t ctrl;
  int num_errors = 0;
  int samples_checked = 0;

  udr_regs uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr), .rd_en_i(rd_en),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .sense_i(sense), .tx_oe_active_i(tx_oe),
    .auto_connect_enable_i(acon_en), .rise_irq_en_i(rise_en), .fall_irq_en_i(fall_en),
    .line_ctrl_o(ctrl), .src_o(src), .latch_o(latch));
  udr_host_model host (.clk_i(clk_i), .wr_o(wr), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
    .rd_data_i(rd_data));

  // 125 MHz clock
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] g;
    host.rd(a, g);
    `CHK("rd_data", e, g)
  endtask

  // sense edges need two sync flops plus the latch edge
  task automatic settle();
    repeat (4) @(negedge clk_i);
  endtask

  task automatic t_reset();
    `CHK("ctrl", 8'h0C, ctrl)
    rdchk(8'h07, 8'h0C);
    rdchk(8'h08, 8'h00);
    rdchk(8'h0A, 8'h00);
    rdchk(8'h10, 8'h00);
    rdchk(8'h20, 8'h00);
  endtask

  task automatic t_ctrl();
    logic [7:0] e;
    e = 8'h0C;
    for (int i = 0; i < 8; i++)
    begin
      host.wr(8'h06, 8'h01 << i);
      e[i] = 1'b1;
      `CHK("ctrl set", e, ctrl)
    end
    host.wr(8'h07, 8'h00);
    `CHK("ctrl zeros", 8'hFF, ctrl)
    for (int i = 0; i < 8; i++)
    begin
      host.wr(8'h07, 8'h80 >> i);
      e[7-i] = 1'b0;
      `CHK("ctrl clr", e, ctrl)
    end
    rdchk(8'h06, 8'h00);
    host.wr(8'h06, 8'h0C);
  endtask

  task automatic t_sense();
    udr_sense_t s;
    logic [7:0] e;
    for (int k = 0; k < 9; k++)
    begin
      s = 9'h001 << k;
      e = {s[6], 1'b0, s[5:0]};
      @(negedge clk_i);
      sense = s;
      settle();
      `CHK("src", e, src)
      rdchk(8'h08, e);
      e = {s[8:7], 6'h00};
      rdchk(8'h10, e);
    end
    sense = '0;
    settle();
    `CHK("latch off", 8'h00, latch)
  endtask

  task automatic t_latch();
    rise_en = 8'h04;
    sense.dplus_high = 1'b1;
    settle();
    `CHK("latch rise", 8'h04, latch)
    host.wr(8'h0B, 8'h04);
    `CHK("latch clr", 8'h00, latch)
    rise_en = 8'h00;
    fall_en = 8'h04;
    sense.dplus_high = 1'b0;
    sense.id_open = 1'b1;
    settle();
    `CHK("latch fall", 8'h04, latch)
    host.wr(8'h0A, 8'hA0);
    `CHK("latch set", 8'hA4, latch)
    rdchk(8'h0B, 8'hA4);
    host.wr(8'h0B, 8'hFF);
    `CHK("latch clr all", 8'h00, latch)
    fall_en = 8'h00;
    sense.id_open = 1'b0;
    settle();
  endtask

  task automatic t_acon();
    tx_oe = 1'b1;
    settle();
    acon_en = 1'b1;
    rise_en = 8'h40;
    settle();
    `CHK("acon tx", 8'h0C, ctrl)
    tx_oe = 1'b0;
    settle();
    `CHK("acon ctrl", 8'h0D, ctrl)
    `CHK("acon src", 8'h40, src)
    `CHK("acon latch", 8'h40, latch)
    acon_en = 1'b0;
    rise_en = 8'h00;
    settle();
    `CHK("acon off", 8'h00, src)
    host.wr(8'h07, 8'h01);
    `CHK("acon clr", 8'h0C, ctrl)
  endtask

  // refused write, then a reset in mid-run with control, latch and read data dirty
  task automatic t_reset_mid();
    host.wr(8'h06, 8'hF3);
    host.wr(8'h0A, 8'h0F);
    host.wr(8'h08, 8'hFF);
    `CHK("ctrl pre", 8'hFF, ctrl)
    `CHK("latch pre", 8'h4F, latch)
    `CHK("src ro", 8'h00, src)
    reset_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    `CHK("ctrl in reset", 8'h0C, ctrl)
    `CHK("latch in reset", 8'h00, latch)
    reset_n_i = 1'b1;
    t_reset();
    `CHK("latch after reset", 8'h00, latch)
  endtask

  // main sequence, reset held two cycles
  initial
  begin
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    t_reset();
    t_ctrl();
    t_sense();
    t_latch();
    t_acon();
    t_reset_mid();
    conclude();
  end

  // run needs well under a thousand cycles
  initial
  begin
    #20us;
    num_errors++;
    conclude();
  end
endmodule
